// >>> hdl/otgdr_ctrl.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "otgdr_params.svh"
module otgdr_ctrl #(
  parameter int TICK_CYC = `OTGDR_TICK_CYC // prescaler cycles per tick
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic id_a_plug, // level: high when type-a plug inserted
  input wire logic supply_valid_flag,
  input wire logic hs_session_valid_flag,
  input wire logic ps_session_valid_flag,
  input wire logic ps_session_end_flag,
  input wire logic partner_conn, // partner pull-up seen (attach level)
  input wire logic bus_idle,
  input wire logic bus_suspend,
  input wire logic bus_resume,
  input wire logic srp_seen, // partner data-line pulsing confirmed
  output logic bus_power_drive,
  output logic bus_power_charge,
  output logic dplus_pullup,
  output logic host_mode_en,
  output otgdr_pkg::otgdr_state_e state_out
);
  import otgdr_pkg::*;

  localparam int PW = $clog2(TICK_CYC + 1); // prescaler width

  // all state of the block
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    otgdr_state_e st;
    logic [PW-1:0] pre;
    otgdr_tick_t tk;
    logic [4:0] ctrl;
    logic done_pend;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic drv;
    logic chg;
    logic dp;
    logic host;
  } otgdr_s;

  otgdr_s s_q;
  otgdr_s s_d;

  // synchronised inputs, named by bit
  logic id_s, vv_s, asv_s, bsv_s, bse_s, con_s, idle_s, susp_s;
  logic id_ev, vv_rise, vv_fall, bsv_rise, bsv_fall, con_rise, con_fall;
  logic tick;
  logic wr;
  logic rd;

  // true once the state timer has reached n ticks
  function automatic logic after_ticks(otgdr_tick_t t, int n);
    return t >= otgdr_tick_t'(n);
  endfunction

  assign id_s = s_q.sync2[0];
  assign vv_s = s_q.sync2[1];
  assign asv_s = s_q.sync2[2];
  assign bsv_s = s_q.sync2[3];
  assign bse_s = s_q.sync2[4];
  assign con_s = s_q.sync2[5];
  assign idle_s = s_q.sync2[6];
  assign susp_s = s_q.sync2[7];
  // edge events from the second stage only
  assign id_ev = id_s ^ s_q.prev[0];
  assign vv_rise = vv_s & ~s_q.prev[1];
  assign vv_fall = ~vv_s & s_q.prev[1];
  assign bsv_rise = bsv_s & ~s_q.prev[3];
  assign bsv_fall = ~bsv_s & s_q.prev[3];
  assign con_rise = con_s & ~s_q.prev[5];
  assign con_fall = ~con_s & s_q.prev[5];
  assign tick = (s_q.pre == PW'(TICK_CYC - 1));
  assign wr = psel & penable & pwrite & ~s_q.ready;
  assign rd = psel & penable & ~pwrite & ~s_q.ready;

  // next state
  always_comb begin
    logic want;
    logic done;
    logic yield;
    logic hnp;
    logic notmo;
    logic go;
    otgdr_state_e nx;
    want = 1'b0;
    done = 1'b0;
    yield = 1'b0;
    hnp = 1'b0;
    notmo = 1'b0;
    go = 1'b0;
    nx = OTGDR_A_IDLE;
    s_d = s_q;
    // two-flop synchronisers for the eight status pins; srp_seen and bus_resume are used unsynchronised
    s_d.sync1 = {bus_suspend, bus_idle, partner_conn, ps_session_end_flag,
                 ps_session_valid_flag, hs_session_valid_flag, supply_valid_flag, id_a_plug};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    // prescaler producing the tick
    s_d.pre = tick ? '0 : s_q.pre + PW'(1);
    want = s_q.ctrl[`OTGDR_CTRL_WANT];
    done = s_q.done_pend;
    yield = s_q.ctrl[`OTGDR_CTRL_YIELD];
    hnp = s_q.ctrl[`OTGDR_CTRL_HNP];
    notmo = s_q.ctrl[`OTGDR_CTRL_NOTMO];
    nx = s_q.st;
    // role sequencing
    unique case (s_q.st)
      OTGDR_A_IDLE: begin
        // plug level kept as a pending change: an edge swallowed elsewhere still lands here
        if (!id_s) begin
          nx = OTGDR_B_IDLE;
        end else if (want || srp_seen) begin
          nx = OTGDR_A_RAMP;
        end
      end
      OTGDR_A_RAMP: begin
        if (id_ev || (!vv_s && after_ticks(s_q.tk, `OTGDR_VRISE_TK))) begin
          nx = OTGDR_A_DECAY;
        end else if (vv_s) begin
          nx = OTGDR_A_AWAIT;
        end
      end
      OTGDR_A_AWAIT: begin
        if (id_ev || (!notmo && after_ticks(s_q.tk, `OTGDR_BCON_TK))) begin
          nx = OTGDR_A_DECAY;
        end else if (vv_s && con_s) begin
          nx = OTGDR_A_HOST;
        end
      end
      OTGDR_A_HOST: begin
        if (vv_fall || (done && !yield)) begin
          nx = OTGDR_A_DECAY;
        end else if (done && yield) begin
          nx = OTGDR_A_SUSP;
        end else if (id_ev || con_fall) begin
          nx = OTGDR_A_AWAIT;
        end
      end
      OTGDR_A_SUSP: begin
        if (hnp && con_fall && !after_ticks(s_q.tk, `OTGDR_ADISC_TK)) begin
          nx = OTGDR_A_PERI;
        end else if (id_ev || vv_fall || after_ticks(s_q.tk, `OTGDR_ADISC_TK)) begin
          nx = OTGDR_A_DECAY;
        end else if (want && !yield) begin
          nx = OTGDR_A_HOST;
        end
      end
      OTGDR_A_PERI: begin
        if (id_ev || vv_rise) begin
          nx = OTGDR_A_DECAY;
        end else if (after_ticks(s_q.tk, `OTGDR_AIDLE_TK)) begin
          nx = OTGDR_A_AWAIT;
        end
      end
      OTGDR_A_DECAY: begin
        if (id_ev || (!asv_s && !con_s)) begin
          nx = OTGDR_A_IDLE;
        end
      end
      OTGDR_B_IDLE: begin
        // type-a plug present while resting as peripheral
        if (id_s) begin
          nx = OTGDR_A_IDLE;
        end else if (bsv_rise || bsv_s) begin
          nx = OTGDR_B_PERI;
        end else if (want && bse_s && after_ticks(s_q.tk, `OTGDR_BIDLE_TK)) begin
          nx = OTGDR_B_SRP;
        end
      end
      OTGDR_B_SRP: begin
        if (id_ev || after_ticks(s_q.tk, `OTGDR_SRP_PULSE_TK)) begin
          nx = OTGDR_B_IDLE;
        end
      end
      OTGDR_B_PERI: begin
        if (hnp && susp_s && want) begin
          nx = OTGDR_B_AWAIT;
        end else if (id_ev || bsv_fall) begin
          nx = OTGDR_B_IDLE;
        end
      end
      OTGDR_B_AWAIT: begin
        if (id_ev || bsv_fall) begin
          nx = OTGDR_B_IDLE;
        end else if (con_rise) begin
          nx = OTGDR_B_HOST;
        end else if (bus_resume || after_ticks(s_q.tk, `OTGDR_ACON_TK)) begin
          nx = OTGDR_B_PERI;
        end
      end
      OTGDR_B_HOST: begin
        if (id_ev || bsv_fall) begin
          nx = OTGDR_B_IDLE;
        end else if (done || con_fall) begin
          nx = OTGDR_B_PERI;
        end
      end
      default: nx = OTGDR_A_IDLE;
    endcase
    go = (nx != s_q.st);
    s_d.st = nx;
    // timer restarts on entry; idle timer in rest needs bus idle
    if (go || (s_q.st == OTGDR_B_IDLE && !idle_s) || (s_q.st == OTGDR_A_PERI && !idle_s)) begin
      s_d.tk = '0;
    end else if (tick && s_q.tk != '1) begin
      s_d.tk = s_q.tk + otgdr_tick_t'(1);
    end
    // outputs follow the state
    s_d.drv = (nx == OTGDR_A_RAMP) || (nx == OTGDR_A_AWAIT) || (nx == OTGDR_A_HOST) ||
              (nx == OTGDR_A_SUSP) || (nx == OTGDR_A_PERI);
    s_d.host = (nx == OTGDR_A_AWAIT) || (nx == OTGDR_A_HOST) || (nx == OTGDR_A_SUSP) ||
               (nx == OTGDR_B_HOST);
    s_d.dp = (nx == OTGDR_B_PERI) || (nx == OTGDR_A_PERI) ||
             (nx == OTGDR_B_SRP && !after_ticks(s_d.tk, `OTGDR_SRP_PULSE_TK));
    s_d.chg = (nx == OTGDR_B_SRP) && !after_ticks(s_d.tk, `OTGDR_SRP_PULSE_TK);
    // done strobe consumed by the state machine; a new write wins
    if (done && go) begin
      s_d.done_pend = 1'b0;
    end
    // apb slave, one wait state per access (pready registered)
    s_d.ready = psel & penable & ~s_q.ready;
    s_d.err = 1'b0;
    if (wr) begin
      if (paddr == `OTGDR_CTRL_ADDR) begin
        s_d.ctrl = pwdata[4:0];
        if (pwdata[`OTGDR_CTRL_DONE]) begin
          s_d.done_pend = 1'b1;
        end
      end else if (paddr != `OTGDR_STAT_ADDR && paddr != `OTGDR_STATE_ADDR) begin
        s_d.err = 1'b1;
      end
    end
    if (rd) begin
      unique case (paddr)
        `OTGDR_CTRL_ADDR: s_d.rdata = {27'h0, s_q.ctrl};
        `OTGDR_STAT_ADDR: s_d.rdata = {20'h0, s_q.host, s_q.dp, s_q.chg, s_q.drv, s_q.sync2};
        `OTGDR_STATE_ADDR: s_d.rdata = {28'h0, s_q.st};
        default: begin
          s_d.rdata = 32'h0;
          s_d.err = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{sync1: 8'h00, sync2: 8'h00, prev: 8'h00, st: OTGDR_B_IDLE, pre: '0,
               tk: 16'h0000, ctrl: 5'h00, done_pend: 1'b0, rdata: 32'h0, ready: 1'b0,
               err: 1'b0, drv: 1'b0, chg: 1'b0, dp: 1'b0, host: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign bus_power_drive = s_q.drv;
  assign bus_power_charge = s_q.chg;
  assign dplus_pullup = s_q.dp;
  assign host_mode_en = s_q.host;
  assign state_out = s_q.st;

  // checks
  role_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(s_q.host && s_q.dp)) else $error("host and pull-up together");
  ramp_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_A_RAMP) |-> s_q.drv) else $error("ramp without drive");
  decay_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_A_DECAY) |-> !s_q.drv && !s_q.host) else $error("decay drives");
  hosting_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_A_HOST || s_q.st == OTGDR_B_HOST) |-> s_q.host) else $error("no host en");
  serve_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_B_PERI) |-> s_q.dp) else $error("no pull-up serving");
  await_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_B_AWAIT) |-> !s_q.dp) else $error("pull-up in await");
  ramp_tmo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_A_RAMP && !id_ev && !vv_s && s_q.tk >= otgdr_tick_t'(`OTGDR_VRISE_TK))
    |=> s_q.st == OTGDR_A_DECAY) else $error("ramp timeout missed");
  timer_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st != $past(s_q.st)) |-> s_q.tk == '0) else $error("timer not restarted");
  srp_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == OTGDR_B_SRP) |-> s_q.tk <= otgdr_tick_t'(`OTGDR_SRP_MAX_TK)) else $error("srp too long");
  apb_ans_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !s_q.ready) |=> s_q.ready) else $error("apb no answer");
  host_cov_c: cover property (@(posedge pclk) disable iff (!presetn) s_q.st == OTGDR_A_HOST);
  bhost_cov_c: cover property (@(posedge pclk) disable iff (!presetn) s_q.st == OTGDR_B_HOST);
  srp_cov_c: cover property (@(posedge pclk) disable iff (!presetn) s_q.st == OTGDR_B_SRP);
  aperi_cov_c: cover property (@(posedge pclk) disable iff (!presetn) s_q.st == OTGDR_A_PERI);
endmodule // otgdr_ctrl

// >>> shared/otgdr_params.svh
`ifndef OTGDR_PARAMS_SVH
`define OTGDR_PARAMS_SVH
// clock and timer base
`define OTGDR_CLK_MHZ 100
`define OTGDR_TICK_US 100
`define OTGDR_TICK_CYC (`OTGDR_TICK_US * `OTGDR_CLK_MHZ)
// timeouts in microseconds, counted in ticks
`define OTGDR_VRISE_US 100000
`define OTGDR_BCON_US 200000
`define OTGDR_ADISC_US 150000
`define OTGDR_AIDLE_US 3000
`define OTGDR_BIDLE_US 2000
`define OTGDR_SRP_PULSE_US 5000
`define OTGDR_SRP_MAX_US 100000
`define OTGDR_ACON_US 3125
// round up for least times, down for longest
`define OTGDR_VRISE_TK (`OTGDR_VRISE_US / `OTGDR_TICK_US)
`define OTGDR_BCON_TK (`OTGDR_BCON_US / `OTGDR_TICK_US)
`define OTGDR_ADISC_TK (`OTGDR_ADISC_US / `OTGDR_TICK_US)
`define OTGDR_AIDLE_TK ((`OTGDR_AIDLE_US + `OTGDR_TICK_US - 1) / `OTGDR_TICK_US)
`define OTGDR_BIDLE_TK ((`OTGDR_BIDLE_US + `OTGDR_TICK_US - 1) / `OTGDR_TICK_US)
`define OTGDR_SRP_PULSE_TK ((`OTGDR_SRP_PULSE_US + `OTGDR_TICK_US - 1) / `OTGDR_TICK_US)
`define OTGDR_SRP_MAX_TK (`OTGDR_SRP_MAX_US / `OTGDR_TICK_US)
`define OTGDR_ACON_TK ((`OTGDR_ACON_US + `OTGDR_TICK_US - 1) / `OTGDR_TICK_US)
// register map, byte addresses
`define OTGDR_CTRL_ADDR 12'h000
`define OTGDR_STAT_ADDR 12'h004
`define OTGDR_STATE_ADDR 12'h008
// control bit positions
`define OTGDR_CTRL_WANT 0
`define OTGDR_CTRL_DONE 1
`define OTGDR_CTRL_YIELD 2
`define OTGDR_CTRL_HNP 3
`define OTGDR_CTRL_NOTMO 4
`define OTGDR_CTRL_RESET 8'h00
`endif

// >>> shared/otgdr_pkg.sv
package otgdr_pkg;
  // controller states
  typedef enum logic [3:0] {
    OTGDR_A_IDLE = 4'h0,
    OTGDR_A_RAMP = 4'h1,
    OTGDR_A_AWAIT = 4'h2,
    OTGDR_A_HOST = 4'h3,
    OTGDR_A_SUSP = 4'h4,
    OTGDR_A_PERI = 4'h5,
    OTGDR_A_DECAY = 4'h6,
    OTGDR_B_IDLE = 4'h7,
    OTGDR_B_SRP = 4'h8,
    OTGDR_B_PERI = 4'h9,
    OTGDR_B_AWAIT = 4'ha,
    OTGDR_B_HOST = 4'hb
  } otgdr_state_e;
  typedef logic [15:0] otgdr_tick_t;
endpackage

// >>> sim/otgdr_partner.sv
`timescale 1ns/1ps
// far-side device: powers the bus, attaches, answers our supply
module otgdr_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_power_drive, // our supply switch
  input wire logic p_power, // far side powers the bus
  input wire logic p_attach, // far side pull-up on
  input wire logic p_slow, // supply never reaches valid
  output logic supply_valid_flag,
  output logic hs_session_valid_flag,
  output logic ps_session_valid_flag,
  output logic ps_session_end_flag,
  output logic partner_conn
);
  logic [3:0] ramp_q; // supply rise delay count
  // supply follows drive after a short rise, drops at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= 4'h0;
      supply_valid_flag <= 1'b0;
    end else begin
      ramp_q <= bus_power_drive ? ramp_q + {3'h0, ramp_q != 4'hf} : 4'h0;
      supply_valid_flag <= bus_power_drive && !p_slow && ramp_q > 4'h7;
    end
  end
  // ps session sensors and attach follow the far side, hs session follows the supply
  assign hs_session_valid_flag = supply_valid_flag;
  assign ps_session_valid_flag = p_power;
  assign ps_session_end_flag = !p_power;
  assign partner_conn = p_attach;
endmodule // otgdr_partner

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "otgdr_params.svh"
module tb;
  import otgdr_pkg::*;
  localparam int TK = 2; // cycles per tick, shortened
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic id_a_plug, bus_idle, bus_suspend, bus_resume, srp_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic drv, chg, pup, hme, sv, hsv, psv, pse, conn, p_power, p_attach, p_slow;
  otgdr_state_e st;
  int errors, n_compared;
  otgdr_ctrl #(.TICK_CYC(TK)) otgdr_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .id_a_plug(id_a_plug), .supply_valid_flag(sv), .hs_session_valid_flag(hsv), .ps_session_valid_flag(psv),
    .ps_session_end_flag(pse), .partner_conn(conn), .bus_idle(bus_idle), .bus_suspend(bus_suspend),
    .bus_resume(bus_resume), .srp_seen(srp_seen), .bus_power_drive(drv), .bus_power_charge(chg),
    .dplus_pullup(pup), .host_mode_en(hme), .state_out(st));
  otgdr_partner otgdr_partner_i (.pclk(pclk), .presetn(presetn), .bus_power_drive(drv), .p_power(p_power),
    .p_attach(p_attach), .p_slow(p_slow), .supply_valid_flag(sv), .hs_session_valid_flag(hsv),
    .ps_session_valid_flag(psv), .ps_session_end_flag(pse), .partner_conn(conn));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for a state, then one edge more; outputs change with the state
  task automatic wait_st(input otgdr_state_e exp, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge pclk);
      if (st === exp) break;
    end
    check("state", 32'(st), 32'(exp));
    if (st !== exp) stop_test();
    @(posedge pclk);
  endtask
  // timed move: not early, then within a few ticks
  task automatic tmo(input otgdr_state_e exp, input int ticks);
    repeat ((ticks - 2) * TK) @(posedge pclk);
    check("early move", 32'(st === exp), 32'h0);
    wait_st(exp, 4 * TK + 10);
  endtask
  // drive, charge, pull-up, host enable
  task automatic outs(input logic [3:0] e);
    check("outputs", {28'h0, drv, chg, pup, hme}, {28'h0, e});
  endtask
  // reset values and register map edges
  task automatic sc_reset();
    check("rest state", 32'(st), 32'(OTGDR_B_IDLE));
    outs(4'b0000);
    apb(1'b0, `OTGDR_CTRL_ADDR, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
  endtask
  // peripheral roles and role swap
  task automatic sc_b_roles();
    p_power <= 1'b1;
    wait_st(OTGDR_B_PERI, 20);
    outs(4'b0010);
    bus_suspend <= 1'b1;
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h9);
    wait_st(OTGDR_B_AWAIT, 20);
    outs(4'b0000);
    tmo(OTGDR_B_PERI, 32);
    wait_st(OTGDR_B_AWAIT, 20);
    bus_resume <= 1'b1;
    wait_st(OTGDR_B_PERI, 20);
    bus_resume <= 1'b0;
    wait_st(OTGDR_B_AWAIT, 20);
    p_attach <= 1'b1;
    wait_st(OTGDR_B_HOST, 20);
    outs(4'b0001);
    p_attach <= 1'b0;
    wait_st(OTGDR_B_PERI, 20);
    wait_st(OTGDR_B_AWAIT, 20);
    p_power <= 1'b0;
    wait_st(OTGDR_B_IDLE, 20);
    bus_suspend <= 1'b0;
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h0);
  endtask
  // session request from peripheral rest
  task automatic sc_srp();
    bus_idle <= 1'b1;
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h1);
    tmo(OTGDR_B_SRP, 20);
    outs(4'b0110);
    tmo(OTGDR_B_IDLE, 50);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h0);
    bus_idle <= 1'b0;
  endtask
  // host-side session with swap to serving
  task automatic sc_a_host();
    id_a_plug <= 1'b1;
    wait_st(OTGDR_A_IDLE, 20);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h9);
    wait_st(OTGDR_A_RAMP, 20);
    outs(4'b1000);
    wait_st(OTGDR_A_AWAIT, 40);
    p_attach <= 1'b1;
    wait_st(OTGDR_A_HOST, 20);
    outs(4'b1001);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'hf);
    wait_st(OTGDR_A_SUSP, 20);
    p_attach <= 1'b0;
    wait_st(OTGDR_A_PERI, 20);
    check("host off", {31'h0, hme}, 32'h0);
    bus_idle <= 1'b1;
    tmo(OTGDR_A_AWAIT, 30);
    check("host on", {31'h0, hme}, 32'h1);
    bus_idle <= 1'b0;
    p_attach <= 1'b1;
    wait_st(OTGDR_A_HOST, 20);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h2);
    wait_st(OTGDR_A_DECAY, 20);
    outs(4'b0000);
    p_attach <= 1'b0;
    wait_st(OTGDR_A_IDLE, 20);
  endtask
  // pause: resume hosting, disconnect back to await, pause timeout
  task automatic sc_a_pause();
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h1);
    p_attach <= 1'b1;
    wait_st(OTGDR_A_HOST, 60);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h7);
    wait_st(OTGDR_A_SUSP, 20);
    apb(1'b0, `OTGDR_STATE_ADDR, 32'h0);
    check("state reg", rd, 32'(OTGDR_A_SUSP));
    apb(1'b0, `OTGDR_STAT_ADDR, 32'h0);
    check("status reg", rd, 32'h0000_0937);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h1);
    wait_st(OTGDR_A_HOST, 20);
    p_attach <= 1'b0;
    wait_st(OTGDR_A_AWAIT, 20);
    outs(4'b1001);
    p_attach <= 1'b1;
    wait_st(OTGDR_A_HOST, 20);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h6);
    wait_st(OTGDR_A_SUSP, 20);
    tmo(OTGDR_A_DECAY, 1500);
    outs(4'b0000);
    p_attach <= 1'b0;
    wait_st(OTGDR_A_IDLE, 20);
  endtask
  // supply and partner timeouts, then partner request
  task automatic sc_a_timeouts();
    p_slow <= 1'b1;
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h1);
    wait_st(OTGDR_A_RAMP, 20);
    tmo(OTGDR_A_DECAY, 1000);
    p_slow <= 1'b0;
    wait_st(OTGDR_A_RAMP, 100);
    apb(1'b1, `OTGDR_CTRL_ADDR, 32'h0);
    wait_st(OTGDR_A_AWAIT, 100);
    tmo(OTGDR_A_DECAY, 2000);
    wait_st(OTGDR_A_IDLE, 20);
    srp_seen <= 1'b1;
    wait_st(OTGDR_A_RAMP, 20);
    srp_seen <= 1'b0;
    id_a_plug <= 1'b0;
    wait_st(OTGDR_B_IDLE, 40);
  endtask
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    stop_test();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, id_a_plug, bus_idle, bus_suspend, bus_resume, srp_seen} = '0;
    {p_power, p_attach, p_slow} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_reset();
    sc_b_roles();
    sc_srp();
    sc_a_host();
    sc_a_pause();
    sc_a_timeouts();
    stop_test();
  end
endmodule // tb
